// ---- backlight_defs.svh ----
`ifndef BACKLIGHT_DEFS_SVH
`define BACKLIGHT_DEFS_SVH
`define CLK_MHZ 250
`define CURRENT_SETTING_CONTROL_OFFSET 8'h02
`define CURRENT_SETTING_CONTROL_RESET 8'h00
`define CURRENT_SETTING_CONTROL_ENA_BIT 0
`define CURRENT_SETTING_CONTROL_PSEN_BIT 1
`define UV_BLANK_MS 52
`define UV_BLANK_CYC (`UV_BLANK_MS * 1000 * `CLK_MHZ)
`define HEAD_TICK_MS 10
`define HEAD_TICK_CYC (`HEAD_TICK_MS * 1000 * `CLK_MHZ)
`define DIM_SAMPLE_MHZ 20
`define DIM_SAMPLE_CYC (`CLK_MHZ / `DIM_SAMPLE_MHZ)
`define ADDR_LOW 7'h60
`define ADDR_HIGH 7'h66
`define DAC_RESET 8'h80
`endif

// ---- backlight_pkg.sv ----
package backlight_pkg;
    typedef enum logic [1:0] {ST_OFF, ST_SOFT, ST_RUN, ST_UV} pwr_state_t;
    typedef enum logic [2:0] {FS_OFF, FS_25, FS_50, FS_75, FS_100} fs_cur_t;
endpackage

// ---- backlight_boost_headroom_fault_control.sv ----
`timescale 1ns/1ps
`include "backlight_defs.svh"
module backlight_boost_headroom_fault_control
    import backlight_pkg::*;
#(
    parameter int CHANNELS = 6,
    parameter int UV_BLANK_CYCLES = `UV_BLANK_CYC,
    parameter int HEAD_TICK_CYCLES = `HEAD_TICK_CYC
)
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic clk_en_in,
    // Device pins
    input wire logic enable_pin_in,
    input wire logic failsafe_force_pin_in,
    input wire logic [3:0] failsafe_strap_in,
    input wire logic boost_output_monitor_uv_in,
    input wire logic dim_in,
    input wire logic dim_full_in,
    input wire logic osc_cycle_start_in,
    input wire logic cs_over_comp_in,
    input wire logic ext_sync_in,
    input wire logic [CHANNELS-1:0] chan_active_in,
    input wire logic [CHANNELS-1:0] head_low_in,
    input wire logic [CHANNELS-1:0] head_high_in,
    input wire logic [7:0] diag_flags_in,
    input wire logic [7:0] diag_mask_in,
    // Register port
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // Outputs
    output logic fault_out_n_oe_out,
    output logic regulator_en_out,
    output logic iface_en_out,
    output logic boost_en_out,
    output logic input_disconnect_gate_out,
    output logic switch_gate_drive_out,
    output logic [CHANNELS-1:0] sink_force_full_out,
    output logic spread_en_out,
    output logic [7:0] ref_dac_out,
    output logic [2:0] fs_current_out,
    output logic [6:0] bus_addr_out,
    output logic soft_start_done_out
);
    // ==========================================
    // Registers
    // ==========================================
    localparam int BW = 32;
    pwr_state_t st_r, st_nxt;
    logic [7:0] current_setting_control_r, current_setting_control_nxt;
    logic [BW-1:0] blank_r, blank_nxt;
    logic [BW-1:0] tick_r, tick_nxt;
    logic [7:0] dac_r, dac_nxt;
    logic [7:0] div_r, div_nxt;
    logic dim_s_r, dim_s_nxt;
    logic strap_done_r, strap_done_nxt;
    logic [2:0] fs_r, fs_nxt;
    logic [6:0] addr_r, addr_nxt;
    logic gate_r, gate_nxt;
    logic any_low, all_high, step, ena_wr, ena_now;
    logic fault_any;

    assign ena_now = current_setting_control_r[`CURRENT_SETTING_CONTROL_ENA_BIT];
    assign ena_wr = reg_wr_in && enable_pin_in && reg_addr_in == `CURRENT_SETTING_CONTROL_OFFSET;
    assign any_low = |(chan_active_in & head_low_in);
    assign all_high = (chan_active_in != '0) &&
        ((chan_active_in & head_high_in) == chan_active_in);

    // ==========================================
    // Next-state logic
    // ==========================================
    always_comb
    begin
        st_nxt = st_r;
        current_setting_control_nxt = current_setting_control_r;
        blank_nxt = blank_r;
        tick_nxt = tick_r;
        dac_nxt = dac_r;
        div_nxt = div_r;
        dim_s_nxt = dim_s_r;
        strap_done_nxt = strap_done_r;
        fs_nxt = fs_r;
        addr_nxt = addr_r;
        gate_nxt = gate_r;
        step = 1'b0;
        if (!strap_done_r)
        begin
            strap_done_nxt = 1'b1;
            addr_nxt = failsafe_strap_in[0] ? `ADDR_HIGH : `ADDR_LOW;
            case (failsafe_strap_in[3:1])
                3'h0: fs_nxt = FS_OFF;
                3'h1: fs_nxt = FS_25;
                3'h2: fs_nxt = FS_50;
                3'h3: fs_nxt = FS_75;
                default: fs_nxt = FS_100;
            endcase
        end
        // dim sampled on a 20 MHz strobe
        if (div_r >= 8'(`DIM_SAMPLE_CYC - 1))
        begin
            div_nxt = 8'h00;
            dim_s_nxt = dim_in;
            if (dim_s_r && !dim_in && !dim_full_in)
                step = 1'b1;
        end
        else
            div_nxt = div_r + 8'h01;
        if (dim_full_in)
        begin
            if (tick_r >= BW'(HEAD_TICK_CYCLES - 1))
            begin
                tick_nxt = '0;
                step = 1'b1;
            end
            else
                tick_nxt = tick_r + BW'(1);
        end
        else
            tick_nxt = '0;
        if (step && any_low && dac_r != 8'hff)
            dac_nxt = dac_r + 8'h01;
        else if (step && all_high && dac_r != 8'h00)
            dac_nxt = dac_r - 8'h01;
        if (ena_wr)
            current_setting_control_nxt = reg_wdata_in;
        case (st_r)
            ST_OFF:
            begin
                if (ena_now)
                begin
                    st_nxt = ST_SOFT;
                    blank_nxt = '0;
                end
            end
            ST_SOFT:
            begin
                if (!ena_now)
                    st_nxt = ST_OFF;
                else if (blank_r >= BW'(UV_BLANK_CYCLES - 1))
                    st_nxt = ST_RUN;
                else
                    blank_nxt = blank_r + BW'(1);
            end
            ST_RUN:
            begin
                if (!ena_now)
                    st_nxt = ST_OFF;
                else if (boost_output_monitor_uv_in)
                    st_nxt = ST_UV;
            end
            ST_UV:
            begin
                if (!ena_now)
                    st_nxt = ST_OFF;
            end
            default: st_nxt = ST_OFF;
        endcase
        if (st_nxt == ST_UV || (st_nxt == ST_OFF && !failsafe_force_pin_in))
            gate_nxt = 1'b0;
        else if (cs_over_comp_in)
            gate_nxt = 1'b0;
        else if (osc_cycle_start_in)
            gate_nxt = 1'b1;
        if (!enable_pin_in)
        begin
            st_nxt = ST_OFF;
            current_setting_control_nxt = `CURRENT_SETTING_CONTROL_RESET;
            gate_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            st_r <= ST_OFF;
            current_setting_control_r <= `CURRENT_SETTING_CONTROL_RESET;
            blank_r <= '0;
            tick_r <= '0;
            dac_r <= `DAC_RESET;
            div_r <= 8'h00;
            dim_s_r <= 1'b0;
            strap_done_r <= 1'b0;
            fs_r <= 3'h0;
            addr_r <= `ADDR_LOW;
            gate_r <= 1'b0;
        end
        else if (clk_en_in)
        begin
            st_r <= st_nxt;
            current_setting_control_r <= current_setting_control_nxt;
            blank_r <= blank_nxt;
            tick_r <= tick_nxt;
            dac_r <= dac_nxt;
            div_r <= div_nxt;
            dim_s_r <= dim_s_nxt;
            strap_done_r <= strap_done_nxt;
            fs_r <= fs_nxt;
            addr_r <= addr_nxt;
            gate_r <= gate_nxt;
        end
    end

    // ==========================================
    // Registered outputs
    // ==========================================
    assign fault_any = |(diag_flags_in & ~diag_mask_in);
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            fault_out_n_oe_out <= 1'b0;
            regulator_en_out <= 1'b0;
            iface_en_out <= 1'b0;
            boost_en_out <= 1'b0;
            input_disconnect_gate_out <= 1'b0;
            sink_force_full_out <= '0;
            spread_en_out <= 1'b0;
            reg_rdata_out <= 8'h00;
            soft_start_done_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            // drive low on unmasked flag or trip
            fault_out_n_oe_out <= fault_any || st_nxt == ST_UV;
            regulator_en_out <= enable_pin_in;
            iface_en_out <= enable_pin_in;
            boost_en_out <= enable_pin_in && (failsafe_force_pin_in ||
                st_nxt == ST_SOFT || st_nxt == ST_RUN);
            input_disconnect_gate_out <= enable_pin_in && st_nxt != ST_UV &&
                (failsafe_force_pin_in || st_nxt != ST_OFF);
            sink_force_full_out <= (enable_pin_in && failsafe_force_pin_in) ?
                {CHANNELS{1'b1}} : '0;
            spread_en_out <= !ext_sync_in;
            reg_rdata_out <= (reg_addr_in == `CURRENT_SETTING_CONTROL_OFFSET) ? current_setting_control_nxt : 8'h00;
            soft_start_done_out <= st_nxt == ST_RUN || st_nxt == ST_UV;
        end
    end
    assign switch_gate_drive_out = gate_r;
    assign ref_dac_out = dac_r;
    assign fs_current_out = fs_r;
    assign bus_addr_out = addr_r;

    // ==========================================
    // Assertions
    // ==========================================
    sequence s_run;
        st_r == ST_RUN && ena_now && enable_pin_in && clk_en_in;
    endsequence
    sequence s_trip;
        ##1 st_r == ST_UV;
    endsequence
    a_uv_trip: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        s_run and boost_output_monitor_uv_in |-> s_trip)
        else $error("undervoltage did not trip");
    a_uv_latch: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        st_r == ST_UV && ena_now && enable_pin_in |=> st_r == ST_UV)
        else $error("trip released without toggle");
    // Fault flop and trip state load on the same edge, so check same cycle
    a_uv_fault: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        st_r == ST_UV |-> fault_out_n_oe_out)
        else $error("fault not driven on trip");
    a_fault_flag: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        clk_en_in && fault_any |=> fault_out_n_oe_out)
        else $error("unmasked flag not reported");
    a_fs_force: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        clk_en_in && enable_pin_in && failsafe_force_pin_in |=>
        boost_en_out && &sink_force_full_out)
        else $error("fail-safe not forced");
    a_blank_hold: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        st_r == ST_SOFT && clk_en_in && ena_now && enable_pin_in &&
        blank_r < BW'(UV_BLANK_CYCLES - 1) |=> st_r == ST_SOFT)
        else $error("blanking ended early");
    a_strap_hold: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        strap_done_r |=> $stable(addr_r) && $stable(fs_r))
        else $error("strap changed after capture");
    a_sw_off: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        clk_en_in && cs_over_comp_in |=> !switch_gate_drive_out)
        else $error("switch not turned off");
    a_spread: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        clk_en_in && ext_sync_in |=> !spread_en_out)
        else $error("spread active while synced");
    a_dac_up: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        clk_en_in && step && any_low && dac_r != 8'hff |=>
        dac_r == $past(dac_r) + 8'h01)
        else $error("counter failed to rise");
    a_shutdown: assert property (
        @(posedge sys_clk_in) disable iff (!resetn_in)
        clk_en_in && !enable_pin_in |=> st_r == ST_OFF && !regulator_en_out)
        else $error("not shut down by pin");
endmodule

// ---- backlight_far_side.sv ----
`timescale 1ns/1ps
// ==========================================================
// Switching-cycle side: oscillator tick and sensed current
module backlight_far_side
#(
    parameter int PERIOD = 16
)
(
    // Clock
    input wire logic sys_clk_in,
    // Clocks from cycle start until current crosses COMP
    input wire logic [7:0] ramp_in,
    // Cycle start and comparator result
    output logic osc_cycle_start_out,
    output logic cs_over_comp_out
);
    logic [7:0] cnt_r = 8'h00;
    logic [7:0] cnt_nxt;
    always_comb
    begin
        cnt_nxt = (cnt_r == 8'(PERIOD - 1)) ? 8'h00 : cnt_r + 8'h01;
    end
    always_ff @(posedge sys_clk_in)
    begin
        cnt_r <= cnt_nxt;
    end
    // A ramp of PERIOD or more never trips within the cycle, like a light load
    assign osc_cycle_start_out = (cnt_r == 8'h00);
    assign cs_over_comp_out = (cnt_r >= ramp_in);
endmodule

// ---- backlight_boost_headroom_fault_control_tb.sv ----
`timescale 1ns/1ps
module backlight_boost_headroom_fault_control_tb
    import backlight_pkg::*;
;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
 $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
    localparam int UVB = 20;
    localparam int HT = 30;
    int num_errors = 0;
    int num_checks = 0;
    logic sys_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic clk_en_in = 1'b1;
    logic enable_pin_in = 1'b0;
    logic failsafe_force_pin_in = 1'b0;
    logic [3:0] failsafe_strap_in = 4'hb;
    logic boost_output_monitor_uv_in = 1'b0;
    logic dim_in = 1'b0;
    logic dim_full_in = 1'b0;
    logic osc_cycle_start_in, cs_over_comp_in;
    logic ext_sync_in = 1'b0;
    logic [5:0] chan_active_in = 6'h3f;
    logic [5:0] head_low_in = 6'h00;
    logic [5:0] head_high_in = 6'h00;
    logic [7:0] diag_flags_in = 8'h00;
    logic [7:0] diag_mask_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h02;
    logic [7:0] reg_wdata_in = 8'h00;
    logic [7:0] ramp = 8'h06;
    logic [7:0] reg_rdata_out, ref_dac_out;
    logic fault_out_n_oe_out, regulator_en_out, iface_en_out;
    logic boost_en_out, input_disconnect_gate_out, switch_gate_drive_out;
    logic spread_en_out, soft_start_done_out;
    logic [5:0] sink_force_full_out;
    logic [2:0] fs_current_out;
    logic [6:0] bus_addr_out;

    backlight_boost_headroom_fault_control #(
        .CHANNELS(6), .UV_BLANK_CYCLES(UVB), .HEAD_TICK_CYCLES(HT)
    ) u_dut (
        .sys_clk_in, .resetn_in, .clk_en_in, .enable_pin_in,
        .failsafe_force_pin_in, .failsafe_strap_in,
        .boost_output_monitor_uv_in, .dim_in, .dim_full_in,
        .osc_cycle_start_in, .cs_over_comp_in, .ext_sync_in,
        .chan_active_in, .head_low_in, .head_high_in, .diag_flags_in,
        .diag_mask_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in,
        .reg_rdata_out, .fault_out_n_oe_out, .regulator_en_out,
        .iface_en_out, .boost_en_out, .input_disconnect_gate_out,
        .switch_gate_drive_out, .sink_force_full_out, .spread_en_out,
        .ref_dac_out, .fs_current_out, .bus_addr_out, .soft_start_done_out
    );
    backlight_far_side #(.PERIOD(16)) u_far (
        .sys_clk_in, .ramp_in(ramp),
        .osc_cycle_start_out(osc_cycle_start_in),
        .cs_over_comp_out(cs_over_comp_in)
    );

    always #2 sys_clk_in = ~sys_clk_in;

    // ==========================================================
    // Helpers
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_in);
        reg_wr_in = 1'b1;
        reg_addr_in = a;
        reg_wdata_in = d;
        @(negedge sys_clk_in);
        reg_wr_in = 1'b0;
        reg_addr_in = 8'h02;
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic dim_fall();
        dim_in = 1'b1;
        cyc(30);
        dim_in = 1'b0;
        cyc(30);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        `CHK(bus_addr_out, 7'h60)
        `CHK(ref_dac_out, 8'h80)
        resetn_in = 1'b1;
        cyc(3);
        failsafe_strap_in = 4'h2;
        cyc(3);
        `CHK(bus_addr_out, 7'h66)
        `CHK(fs_current_out, FS_100)
        $display("test reset done");
    endtask
    task automatic t_enable_uv();
        wr(8'h02, 8'h01);
        `CHK(boost_en_out, 1'b0)
        enable_pin_in = 1'b1;
        cyc(1);
        `CHK(regulator_en_out, 1'b1)
        `CHK(iface_en_out, 1'b1)
        `CHK(reg_rdata_out, 8'h00)
        wr(8'h05, 8'hff);
        // Read back the control byte: stray write must not land
        cyc(1);
        `CHK(reg_rdata_out, 8'h00)
        wr(8'h02, 8'h01);
        boost_output_monitor_uv_in = 1'b1;
        `CHK(reg_rdata_out, 8'h01)
        cyc(8);
        `CHK(boost_en_out, 1'b1)
        boost_output_monitor_uv_in = 1'b0;
        cyc(UVB);
        `CHK(soft_start_done_out, 1'b1)
        boost_output_monitor_uv_in = 1'b1;
        cyc(3);
        `CHK(boost_en_out, 1'b0)
        `CHK(input_disconnect_gate_out, 1'b0)
        `CHK(fault_out_n_oe_out, 1'b1)
        boost_output_monitor_uv_in = 1'b0;
        cyc(5);
        `CHK(boost_en_out, 1'b0)
        wr(8'h02, 8'h00);
        wr(8'h02, 8'h01);
        cyc(2);
        `CHK(boost_en_out, 1'b1)
        `CHK(input_disconnect_gate_out, 1'b1)
        `CHK(fault_out_n_oe_out, 1'b0)
        cyc(UVB + 2);
        $display("test enable and undervoltage done");
    endtask
    task automatic t_fault_switch();
        diag_flags_in = 8'h04;
        diag_mask_in = 8'h04;
        cyc(3);
        `CHK(fault_out_n_oe_out, 1'b0)
        diag_mask_in = 8'hfb;
        cyc(3);
        `CHK(fault_out_n_oe_out, 1'b1)
        diag_flags_in = 8'h00;
        @(negedge sys_clk_in iff osc_cycle_start_in);
        cyc(3);
        `CHK(switch_gate_drive_out, 1'b1)
        cyc(8);
        `CHK(switch_gate_drive_out, 1'b0)
        ramp = 8'h0c;
        @(negedge sys_clk_in iff osc_cycle_start_in);
        cyc(11);
        `CHK(switch_gate_drive_out, 1'b1)
        `CHK(spread_en_out, 1'b1)
        ext_sync_in = 1'b1;
        cyc(3);
        `CHK(spread_en_out, 1'b0)
        $display("test fault and switch done");
    endtask
    task automatic t_head();
        head_low_in = 6'h01;
        dim_fall();
        `CHK(ref_dac_out, 8'h81)
        chan_active_in = 6'h3e;
        head_low_in = 6'h01;
        head_high_in = 6'h3e;
        dim_fall();
        `CHK(ref_dac_out, 8'h80)
        head_high_in = 6'h3c;
        dim_fall();
        `CHK(ref_dac_out, 8'h80)
        // Unused dimming tied high for full duty
        dim_in = 1'b1;
        dim_full_in = 1'b1;
        head_low_in = 6'h02;
        cyc(HT * 2 + 15);
        // Ticks land at 30 and 60 clocks into the 75-clock wait
        `CHK(ref_dac_out, 8'h82)
        $display("test headroom done");
    endtask
    task automatic t_failsafe_off();
        wr(8'h02, 8'h00);
        failsafe_force_pin_in = 1'b1;
        cyc(3);
        `CHK(boost_en_out, 1'b1)
        `CHK(sink_force_full_out, 6'h3f)
        failsafe_force_pin_in = 1'b0;
        cyc(3);
        `CHK(sink_force_full_out, 6'h00)
        `CHK(boost_en_out, 1'b0)
        enable_pin_in = 1'b0;
        cyc(3);
        `CHK(regulator_en_out, 1'b0)
        `CHK(bus_addr_out, 7'h66)
        $display("test failsafe and shutdown done");
    endtask

    initial
    begin
        cyc(20);
        t_reset();
        t_enable_uv();
        t_fault_switch();
        t_head();
        t_failsafe_off();
        finish_test();
    end
    initial
    begin
        #20000;
        num_errors++;
        finish_test();
    end
endmodule
